// >>> rfa_filter.sv
/*
 Receive frame acceptance filter: classifies each frame, decides on the
 channel it goes to, buffers its bytes in a FIFO and counts overruns.
 Assumes frame strobes, match results and overrun indications come from logic
 on the same receive clock; configuration inputs are quasi-static.
*/
`timescale 1ns/100ps
module rfa_filter (
   input  wire logic                        CLOCK_I,              // 25 MHz receive clock
   input  wire logic                        RST_I,                // Sync reset, active high
   input  wire logic                        CE_I,                 // Clock enable
   input  wire logic                        ACCEPT_ALL_FRAMES_EN_I,     // Promiscuous enable
   input  wire logic                        ACCEPT_ERROR_FRAMES_EN_I,   // Error frame enable
   input  wire logic                        ACCEPT_CONTROL_FRAMES_EN_I, // Control frame enable
   input  wire logic                        ACCEPT_SHORT_FRAMES_EN_I,   // Short frame enable
   input  wire logic [rfa_pkg::CHAN_W-1:0]  PROMISC_CHANNEL_SEL_I,      // Promiscuous channel
   input  wire logic [rfa_pkg::LEN_W-1:0]   RX_MAX_FRAME_LEN_I,   // Maximum frame length
   input  wire logic                        UNICAST_EN_I,         // Unicast channel enabled
   input  wire logic                        MULTICAST_EN_I,       // Multicast channel enabled
   input  wire logic                        BROADCAST_EN_I,       // Broadcast channel enabled
   input  wire logic                        SOF_I,                // Frame start pulse
   input  wire logic                        BYTE_VALID_I,         // Frame byte strobe
   input  wire logic [rfa_pkg::DATA_W-1:0]  BYTE_I,               // Frame byte
   input  wire logic                        EOF_I,                // Frame end pulse
   input  wire logic                        ADDR_HIT_I,           // Address entry hit
   input  wire logic                        MATCH_OR_FILTER_BIT_I, // Entry: 1 match, 0 filter
   input  wire logic [rfa_pkg::CHAN_W-1:0]  MATCH_CHANNEL_I,      // Channel of the entry
   input  wire logic                        IS_UNICAST_I,         // Destination is unicast
   input  wire logic                        IS_BROADCAST_I,       // Destination is broadcast
   input  wire logic                        IS_CONTROL_I,         // MAC control frame
   input  wire logic                        CODE_ERR_I,           // Code error seen
   input  wire logic                        ALIGN_ERR_I,          // Alignment error seen
   input  wire logic                        CRC_ERR_I,            // CRC error at frame end
   input  wire logic                        FIFO_SOF_OVERRUN_I,   // No FIFO space at start
   input  wire logic                        DMA_SOF_OVERRUN_I,    // No DMA resource at start
   input  wire logic                        FIFO_MIDDLE_OVERRUN_I, // FIFO ran out mid-frame
   input  wire logic                        DMA_MIDDLE_OVERRUN_I,  // DMA ran out mid-frame
   output logic                             DATA_VALID_O,         // Buffered byte valid
   input  wire logic                        DATA_READY_I,         // Downstream accepts byte
   output logic [rfa_pkg::DATA_W-1:0]       DATA_O,               // Buffered byte
   output logic                             FIFO_FULL_O,          // Buffer cannot take a byte
   output logic                             DONE_O,               // Decision pulse
   output logic                             ACCEPT_O,             // Frame kept
   output logic [rfa_pkg::CHAN_W-1:0]       CHANNEL_O,            // Destination channel
   output logic [2:0]                       FRAME_CLASS_O,        // rfa_class_e value
   output logic                             OVERRUN_FLAG_O,       // First descriptor overrun flag
   output logic                             NO_ADDRESS_MATCH_FLAG_O, // First descriptor no-match
   output logic [rfa_pkg::CNT_W-1:0]        RX_START_OVERRUN_COUNT_O,  // Start overruns
   output logic [rfa_pkg::CNT_W-1:0]        RX_MIDDLE_OVERRUN_COUNT_O, // Middle overruns
   output logic [rfa_pkg::CNT_W-1:0]        RX_DMA_OVERRUN_COUNT_O     // DMA overruns
);
   typedef struct packed {
      rfa_pkg::rfa_state_e         state;
      logic                        en_all;
      logic                        en_err;
      logic                        en_ctl;
      logic                        en_short;
      logic [rfa_pkg::CHAN_W-1:0]  prom_ch;
      logic [rfa_pkg::LEN_W-1:0]   max_len;
      logic [rfa_pkg::LEN_W-1:0]   len;
      logic                        err;
      logic                        mof;
      logic                        dma_middle_overrun;
      logic                        done;
      logic                        accept;
      logic [rfa_pkg::CHAN_W-1:0]  channel;
      logic [2:0]                  cls;
      logic                        ovr_flag;
      logic                        no_address_match_flag_flag;
      logic                        full;
      logic [rfa_pkg::CNT_W-1:0]   sof_cnt;
      logic [rfa_pkg::CNT_W-1:0]   mof_cnt;
      logic [rfa_pkg::CNT_W-1:0]   dma_cnt;
   } rfa_filter_s;

   rfa_filter_s                 r;
   rfa_filter_s                 next_r;
   logic                        fifo_in_ready;
   logic                        fifo_wr;

   // Class set an enable combination lets through, shared by both match paths
   function automatic logic class_passes(input logic [2:0] cls, input logic ctl,
                                         input logic en_err, input logic en_ctl,
                                         input logic en_short);
      logic ok;
      ok = 1'b0;
      unique case (rfa_pkg::rfa_class_e'(cls))
         rfa_pkg::CLS_PROPER:     ok = 1'b1;
         rfa_pkg::CLS_UNDERSIZED: ok = en_short;
         rfa_pkg::CLS_FRAGMENT:   ok = en_short && en_err;
         rfa_pkg::CLS_OVERSIZE,
         rfa_pkg::CLS_JABBER,
         rfa_pkg::CLS_ERROR:      ok = en_err;
         default:                 ok = 1'b0;
      endcase
      // Control frames pass only with their own enable
      return ok && (!ctl || en_ctl);
   endfunction : class_passes

   function automatic logic [rfa_pkg::CNT_W-1:0] bump(input logic [rfa_pkg::CNT_W-1:0] c,
                                                     input logic inc);
      return inc ? c + rfa_pkg::CNT_ONE : c;
   endfunction : bump

   // Bytes are written only for a frame still being received; a middle overrun
   // stops further writes so partial data stays in the buffer.
   assign fifo_wr = CE_I && BYTE_VALID_I && (r.state == rfa_pkg::ST_RECV) && !r.mof &&
                    (r.len < r.max_len);

   always_comb begin
      logic                        is_match;
      logic                        is_err;
      logic                        is_mof;
      logic                        hit_filter;
      logic [2:0]                  cls;
      logic [rfa_pkg::LEN_W-1:0]   flen;
      logic                        sof_ovr;
      is_match   = 1'b0;
      is_err     = 1'b0;
      is_mof     = 1'b0;
      hit_filter = 1'b0;
      cls        = 3'h0;
      flen       = r.len;
      sof_ovr    = FIFO_SOF_OVERRUN_I || DMA_SOF_OVERRUN_I;
      next_r      = r;
      next_r.done = 1'b0;
      next_r.full = !fifo_in_ready;
      unique case (r.state)
         rfa_pkg::ST_IDLE: begin
            if (SOF_I) begin
               // Accept enables are held for the whole frame; type enables are sampled at frame end
               next_r.en_all   = ACCEPT_ALL_FRAMES_EN_I;
               next_r.en_err   = ACCEPT_ERROR_FRAMES_EN_I;
               next_r.en_ctl   = ACCEPT_CONTROL_FRAMES_EN_I;
               next_r.en_short = ACCEPT_SHORT_FRAMES_EN_I;
               next_r.prom_ch  = PROMISC_CHANNEL_SEL_I;
               next_r.max_len  = RX_MAX_FRAME_LEN_I;
               next_r.len      = '0;
               next_r.err      = 1'b0;
               next_r.mof      = 1'b0;
               next_r.dma_middle_overrun  = 1'b0;
               if (sof_ovr) begin
                  // No resources at start: count and discard
                  next_r.sof_cnt = bump(r.sof_cnt, 1'b1);
                  next_r.dma_cnt = bump(r.dma_cnt, DMA_SOF_OVERRUN_I);
                  next_r.state   = rfa_pkg::ST_DROP;
               end else begin
                  next_r.state   = rfa_pkg::ST_RECV;
               end
            end
         end
         // A start-overrun frame is still sized and classed, then forced out below
         rfa_pkg::ST_RECV, rfa_pkg::ST_DROP: begin
            if (BYTE_VALID_I && r.len != '1) begin
               next_r.len = r.len + rfa_pkg::LEN_ONE;
            end
            if (CODE_ERR_I || ALIGN_ERR_I) begin
               next_r.err = 1'b1;
            end
            // Overrun only possible before max length is reached
            if ((FIFO_MIDDLE_OVERRUN_I || DMA_MIDDLE_OVERRUN_I) && r.len < r.max_len &&
                r.state == rfa_pkg::ST_RECV) begin
               next_r.mof     = 1'b1;
               next_r.dma_middle_overrun = r.dma_middle_overrun || DMA_MIDDLE_OVERRUN_I;
            end
            if (EOF_I) begin
               flen   = (BYTE_VALID_I && r.len != '1) ? r.len + rfa_pkg::LEN_ONE : r.len;
               is_err = next_r.err || CRC_ERR_I;
               is_mof = next_r.mof;
               if (flen > r.max_len) begin
                  // Truncated long frame, never an overrun
                  cls    = is_err ? 3'(rfa_pkg::CLS_JABBER) : 3'(rfa_pkg::CLS_OVERSIZE);
                  is_mof = 1'b0;
               end else if (flen < rfa_pkg::MIN_FRAME_LEN) begin
                  cls = is_err ? 3'(rfa_pkg::CLS_FRAGMENT)
                               : 3'(rfa_pkg::CLS_UNDERSIZED);
               end else begin
                  cls = is_err ? 3'(rfa_pkg::CLS_ERROR) : 3'(rfa_pkg::CLS_PROPER);
               end
               // Matching needs an enabled target channel control needs its
               // enable error enables never enter this term
               is_match = ADDR_HIT_I &&
                          (IS_BROADCAST_I ? BROADCAST_EN_I :
                           IS_UNICAST_I ? UNICAST_EN_I : MULTICAST_EN_I) &&
                          (!IS_CONTROL_I || r.en_ctl);
               // Filter entries drop even in promiscuous mode or on a disabled type
               hit_filter = ADDR_HIT_I && !MATCH_OR_FILTER_BIT_I;
               next_r.cls          = cls;
               next_r.ovr_flag     = 1'b0;
               next_r.no_address_match_flag_flag = 1'b0;
               next_r.accept       = 1'b0;
               next_r.channel      = '0;
               if (hit_filter) begin
                  next_r.accept = 1'b0;
               end else if (is_match) begin
                  // Accept-all plays no part here
                  next_r.channel = MATCH_CHANNEL_I;
                  if (is_mof) begin
                     next_r.accept   = r.en_err;
                     next_r.ovr_flag = r.en_err;
                  end else begin
                     next_r.accept = class_passes(cls, IS_CONTROL_I, r.en_err,
                                                  r.en_ctl, r.en_short);
                  end
               end else if (r.en_all) begin
                  next_r.channel      = r.prom_ch;
                  next_r.no_address_match_flag_flag = 1'b1;
                  if (is_mof) begin
                     next_r.accept   = r.en_err;
                     next_r.ovr_flag = r.en_err;
                  end else begin
                     next_r.accept = class_passes(cls, IS_CONTROL_I, r.en_err,
                                                  r.en_ctl, r.en_short);
                  end
                  next_r.no_address_match_flag_flag = next_r.accept;
               end
               if (r.state == rfa_pkg::ST_DROP) begin
                  next_r.accept       = 1'b0;
                  next_r.no_address_match_flag_flag = 1'b0;
                  next_r.channel      = '0;
               end
               // Middle overrun counting: non-matching frames counted only when
               // partial data is kept
               if (is_mof && !hit_filter && (is_match || (r.en_all && r.en_err))) begin
                  next_r.mof_cnt = bump(r.mof_cnt, 1'b1);
                  next_r.dma_cnt = bump(r.dma_cnt, next_r.dma_middle_overrun);
               end
               next_r.done  = 1'b1;
               next_r.state = rfa_pkg::ST_IDLE;
            end
         end
         default: next_r.state = rfa_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         r         <= '0;
         r.state   <= rfa_pkg::ST_IDLE;
         r.max_len <= rfa_pkg::MAX_LEN_RESET;
         r.sof_cnt <= rfa_pkg::CNT_RESET;
         r.mof_cnt <= rfa_pkg::CNT_RESET;
         r.dma_cnt <= rfa_pkg::CNT_RESET;
      end else if (CE_I) begin
         r <= next_r;
      end
   end

   // Buffer full ends writes; the writer raises a middle overrun from FIFO_FULL_O
   rfa_fifo #(
      .WIDTH (rfa_pkg::DATA_W),
      .DEPTH (rfa_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (CLOCK_I),
      .rst_i       (RST_I),
      .ce_i        (CE_I),
      .in_valid_i  (fifo_wr),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (BYTE_I),
      .out_valid_o (DATA_VALID_O),
      .out_ready_i (DATA_READY_I),
      .out_data_o  (DATA_O)
   );

   assign FIFO_FULL_O               = r.full;
   assign DONE_O                    = r.done;
   assign ACCEPT_O                  = r.accept;
   assign CHANNEL_O                 = r.channel;
   assign FRAME_CLASS_O             = r.cls;
   assign OVERRUN_FLAG_O            = r.ovr_flag;
   assign NO_ADDRESS_MATCH_FLAG_O   = r.no_address_match_flag_flag;
   assign RX_START_OVERRUN_COUNT_O  = r.sof_cnt;
   assign RX_MIDDLE_OVERRUN_COUNT_O = r.mof_cnt;
   assign RX_DMA_OVERRUN_COUNT_O    = r.dma_cnt;
endmodule : rfa_filter

// >>> rfa_pkg.sv
/*
 Package for the receive frame acceptance filter: counts, widths, reset values,
 frame classes and state encodings.
 Assumes a 25 MHz receive clock and a synchronous active-high reset.
*/
package rfa_pkg;
   localparam int         CHAN_W          = 3;
   localparam int         LEN_W           = 16;
   localparam int         CNT_W           = 32;
   localparam int         DATA_W          = 8;
   localparam int         FIFO_DEPTH      = 16;
   localparam logic [LEN_W-1:0] MIN_FRAME_LEN   = 16'h0040;
   localparam logic [LEN_W-1:0] MAX_LEN_RESET   = 16'h05ee;
   localparam logic [CNT_W-1:0] CNT_RESET       = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ONE         = 32'h0000_0001;
   localparam logic [LEN_W-1:0] LEN_ONE         = 16'h0001;

   typedef enum logic [2:0] {
      CLS_PROPER,
      CLS_UNDERSIZED,
      CLS_FRAGMENT,
      CLS_OVERSIZE,
      CLS_JABBER,
      CLS_ERROR
   } rfa_class_e;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RECV,
      ST_DROP
   } rfa_state_e;
endpackage : rfa_pkg

// >>> rfa_fifo.sv
/*
 Synchronous FIFO with parameterised width and depth, valid/ready on both sides.
 Assumes one clock; the reader may stall so the FIFO really fills.
*/
`timescale 1ns/100ps
module rfa_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_i,     // Clock
   input  wire logic             rst_i,     // Sync reset, active high
   input  wire logic             ce_i,      // Clock enable
   input  wire logic             in_valid_i, // Write request
   output logic                  in_ready_o, // Space available
   input  wire logic [WIDTH-1:0] in_data_i,  // Write data
   output logic                  out_valid_o, // Data available
   input  wire logic             out_ready_i, // Reader accepts
   output logic      [WIDTH-1:0] out_data_o   // Read data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   cnt;
   } rfa_fifo_s;

   rfa_fifo_s            r;
   rfa_fifo_s            next_r;
   logic [WIDTH-1:0]     mem [DEPTH];
   logic                 do_wr;
   logic                 do_rd;

   assign in_ready_o  = (r.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (r.cnt != '0);
   assign out_data_o  = mem[r.rd];
   assign do_wr       = ce_i && in_valid_i && in_ready_o;
   assign do_rd       = ce_i && out_valid_o && out_ready_i;

   always_comb begin
      next_r = r;
      if (do_wr) next_r.wr = r.wr + 1'b1;
      if (do_rd) next_r.rd = r.rd + 1'b1;
      next_r.cnt = r.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else if (ce_i) begin
         r <= next_r;
      end
      if (do_wr) begin
         mem[r.wr] <= in_data_i;
      end
   end
endmodule : rfa_fifo

// >>> rfa_filter_asserts.sv
/* Assertion checker for rfa_filter: decision pulse, drops, channel, counters, size classes.
   Assumes it is bound to rfa_filter and that clock enable is held high. */
`timescale 1ns/100ps
module rfa_filter_asserts (
   input wire logic        CLOCK_I, RST_I, SOF_I, EOF_I, BYTE_VALID_I, // Clock and framing
   input wire logic        ACCEPT_ALL_FRAMES_EN_I, ADDR_HIT_I, MATCH_OR_FILTER_BIT_I, // Config
   input wire logic        FIFO_SOF_OVERRUN_I, DONE_O, ACCEPT_O, NO_ADDRESS_MATCH_FLAG_O, // Flags
   input wire logic [2:0]  PROMISC_CHANNEL_SEL_I, CHANNEL_O, FRAME_CLASS_O, // Channels, class
   input wire logic [15:0] RX_MAX_FRAME_LEN_I, // Maximum length
   input wire logic [31:0] RX_START_OVERRUN_COUNT_O, RX_MIDDLE_OVERRUN_COUNT_O // Counters
);
   logic        in_f, sofo, allv;
   logic [2:0]  psel;
   logic [15:0] len, maxs;
   // Own copy of the frame window, so checks do not lean on the design's state
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         in_f <= 1'b0;
         len  <= 16'h0000;
      end else if (SOF_I && !in_f) begin
         in_f <= 1'b1;
         len  <= 16'h0000;
         sofo <= FIFO_SOF_OVERRUN_I;
         allv <= ACCEPT_ALL_FRAMES_EN_I;
         psel <= PROMISC_CHANNEL_SEL_I;
         maxs <= RX_MAX_FRAME_LEN_I;
      end else if (in_f) begin
         len  <= len + {15'h0000, BYTE_VALID_I};
         in_f <= !EOF_I;
      end
   end
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);
   a_done_after_eof: assert property (in_f && EOF_I |=> DONE_O)
      else $error("decision pulse missing after frame end");
   a_done_one_cycle: assert property (DONE_O |=> !DONE_O)
      else $error("decision pulse longer than one cycle");
   a_filter_entry_drop: assert property (
      in_f && EOF_I && ADDR_HIT_I && !MATCH_OR_FILTER_BIT_I |=> !ACCEPT_O)
      else $error("filter entry hit was kept");
   a_promisc_channel: assert property (
      DONE_O && NO_ADDRESS_MATCH_FLAG_O |-> CHANNEL_O == psel)
      else $error("promiscuous frame on wrong channel");
   a_no_address_match_flag_needs_all: assert property (
      DONE_O && NO_ADDRESS_MATCH_FLAG_O |-> allv && ACCEPT_O)
      else $error("non-matching frame kept without accept-all");
   a_start_overrun_count: assert property (
      SOF_I && !in_f && FIFO_SOF_OVERRUN_I |=>
      RX_START_OVERRUN_COUNT_O == $past(RX_START_OVERRUN_COUNT_O) + 32'h1)
      else $error("start overrun not counted");
   a_start_overrun_drop: assert property (DONE_O && sofo |-> !ACCEPT_O)
      else $error("start overrun frame kept");
   a_middle_count_when: assert property ($changed(RX_MIDDLE_OVERRUN_COUNT_O) |-> DONE_O)
      else $error("middle overrun counter moved outside a decision");
   a_short_class: assert property (
      DONE_O && len < 16'h0040 |-> FRAME_CLASS_O inside {3'h1, 3'h2})
      else $error("short frame class wrong");
   a_long_class: assert property (
      DONE_O && len > maxs |-> FRAME_CLASS_O inside {3'h3, 3'h4})
      else $error("long frame class wrong");
endmodule : rfa_filter_asserts
bind rfa_filter rfa_filter_asserts u_rfa_filter_asserts (.*);

// >>> rfa_phy_model.sv
/* Frame source in place of the PHY side: start pulse, a run of bytes, end on the last byte.
   Assumes a one-cycle go request while idle and a length of at least one byte. */
`timescale 1ns/100ps
module rfa_phy_model (
   input  wire logic        clk_i,        // Clock
   input  wire logic        go_i,         // Start a frame
   input  wire logic [15:0] len_i,        // Bytes in the frame
   output logic             sof_o,        // Frame start
   output logic             byte_valid_o, // Byte strobe
   output logic [7:0]       byte_o,       // Byte
   output logic             eof_o,        // Frame end
   output logic             busy_o        // Frame in progress
);
   logic [15:0] left;
   initial begin
      {sof_o, byte_valid_o, eof_o, busy_o} = 4'h0;
      byte_o = 8'h00;
      left   = 16'h0000;
   end
   // Data line toggles between strobes so a stray sample right after a strobe never repeats the last byte
   always @(negedge clk_i) begin
      sof_o        <= 1'b0;
      eof_o        <= 1'b0;
      byte_valid_o <= 1'b0;
      byte_o       <= ~byte_o;
      if (go_i && !busy_o) begin
         sof_o  <= 1'b1;
         busy_o <= 1'b1;
         left   <= len_i;
      end else if (busy_o && left != 16'h0000) begin
         byte_valid_o <= 1'b1;
         byte_o       <= left[7:0] ^ 8'h5a;
         left         <= left - 16'h0001;
         eof_o        <= (left == 16'h0001);
      end else begin
         busy_o <= 1'b0;
      end
   end
endmodule : rfa_phy_model

// >>> rfa_filter_tb.sv
/* Self-checking bench for rfa_filter: FIFO fill and drain, enable sweep, overrun cases.
   Assumes the PHY model drives framing and the checker is bound from its own file. */
`timescale 1ns/100ps
module rfa_filter_tb;
   localparam logic [15:0] MAXL = 16'h0050;
   logic CLOCK_I, RST_I, CE_I, ACCEPT_ALL_FRAMES_EN_I, ACCEPT_ERROR_FRAMES_EN_I, UNICAST_EN_I;
   logic ACCEPT_CONTROL_FRAMES_EN_I, ACCEPT_SHORT_FRAMES_EN_I, MULTICAST_EN_I, BROADCAST_EN_I;
   logic SOF_I, BYTE_VALID_I, EOF_I, ADDR_HIT_I, MATCH_OR_FILTER_BIT_I, IS_UNICAST_I;
   logic IS_BROADCAST_I, IS_CONTROL_I, CODE_ERR_I, ALIGN_ERR_I, CRC_ERR_I, FIFO_SOF_OVERRUN_I;
   logic DMA_SOF_OVERRUN_I, FIFO_MIDDLE_OVERRUN_I, DMA_MIDDLE_OVERRUN_I, DATA_READY_I, go, busy;
   logic DATA_VALID_O, FIFO_FULL_O, DONE_O, ACCEPT_O, OVERRUN_FLAG_O, NO_ADDRESS_MATCH_FLAG_O;
   logic [2:0]  PROMISC_CHANNEL_SEL_I, MATCH_CHANNEL_I, CHANNEL_O, FRAME_CLASS_O;
   logic [7:0]  BYTE_I, DATA_O;
   logic [15:0] RX_MAX_FRAME_LEN_I, flen;
   logic [15:0] lens [8];
   logic [31:0] RX_START_OVERRUN_COUNT_O, RX_MIDDLE_OVERRUN_COUNT_O, RX_DMA_OVERRUN_COUNT_O;
   logic [31:0] seed, r, es, em, ed;
   logic [8:0]  exp_q[$];
   logic [8:0]  e;
   logic [6:0]  ov [7];
   logic        rnd_rdy;
   int          bad_count, total_checks, i;
   rfa_filter u_rfa_filter (.*);
   rfa_phy_model u_rfa_phy_model (.clk_i(CLOCK_I), .go_i(go), .len_i(flen), .sof_o(SOF_I),
      .byte_valid_o(BYTE_VALID_I), .byte_o(BYTE_I), .eof_o(EOF_I), .busy_o(busy));
   initial begin
      CLOCK_I = 1'b0;
      forever #20 CLOCK_I = ~CLOCK_I;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : chk
   task automatic wrap_up();
      if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   // Reference decision is worked out from the inputs held for the frame, then the frame runs
   task automatic send(input logic [15:0] n);
      logic er, m, filt, ok, acc, mo;
      logic [2:0] cls;
      er   = CRC_ERR_I | CODE_ERR_I | ALIGN_ERR_I;
      cls  = (n < 16'h0040) ? (er ? 3'h2 : 3'h1) :
             (n > MAXL) ? (er ? 3'h4 : 3'h3) : (er ? 3'h5 : 3'h0);
      filt = ADDR_HIT_I && !MATCH_OR_FILTER_BIT_I;
      m    = ADDR_HIT_I && MATCH_OR_FILTER_BIT_I
             && (!IS_CONTROL_I || ACCEPT_CONTROL_FRAMES_EN_I)
             && (IS_UNICAST_I ? UNICAST_EN_I : IS_BROADCAST_I ? BROADCAST_EN_I : MULTICAST_EN_I);
      ok   = cls == 3'h0 || (cls == 3'h1 && ACCEPT_SHORT_FRAMES_EN_I)
             || (cls > 3'h2 && ACCEPT_ERROR_FRAMES_EN_I)
             || (cls == 3'h2 && ACCEPT_SHORT_FRAMES_EN_I && ACCEPT_ERROR_FRAMES_EN_I);
      mo   = FIFO_MIDDLE_OVERRUN_I | DMA_MIDDLE_OVERRUN_I;
      ok   = mo ? ACCEPT_ERROR_FRAMES_EN_I
                : ok && (!IS_CONTROL_I || ACCEPT_CONTROL_FRAMES_EN_I);
      acc  = !filt && !FIFO_SOF_OVERRUN_I && !DMA_SOF_OVERRUN_I && ok
             && (m || ACCEPT_ALL_FRAMES_EN_I);
      es   = es + {31'h0, FIFO_SOF_OVERRUN_I | DMA_SOF_OVERRUN_I};
      em   = em + {31'h0, mo && !filt && (m || acc)};
      ed   = ed + {31'h0, DMA_SOF_OVERRUN_I | (DMA_MIDDLE_OVERRUN_I && !filt && (m || acc))};
      exp_q.push_back({acc, acc && !m, acc && mo, cls,
                       m ? MATCH_CHANNEL_I : PROMISC_CHANNEL_SEL_I});
      flen = n;
      go <= 1'b1;
      @(negedge CLOCK_I) go <= 1'b0;
      for (int k = 0; k < 400 && (busy || k < 2); k++) @(negedge CLOCK_I);
      repeat (2) @(negedge CLOCK_I);
      chk(RX_START_OVERRUN_COUNT_O, es);
      chk(RX_MIDDLE_OVERRUN_COUNT_O, em);
      chk(RX_DMA_OVERRUN_COUNT_O, ed);
      chk(32'(exp_q.size()), 32'h0);
   endtask : send
   always @(negedge CLOCK_I) begin
      if (DONE_O === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
         chk(32'({ACCEPT_O, NO_ADDRESS_MATCH_FLAG_O, OVERRUN_FLAG_O, FRAME_CLASS_O}),
             32'(e[8:3]));
         if (e[8]) chk(32'(CHANNEL_O), 32'(e[2:0]));
      end
   end
   // Reader stalls at random while frames arrive
   always @(negedge CLOCK_I) if (rnd_rdy) DATA_READY_I = 1'($random(seed));
   initial begin
      repeat (60000) @(posedge CLOCK_I);
      bad_count++;
      wrap_up();
   end
   initial begin
      seed = 32'hf0b91381;
      {ACCEPT_ALL_FRAMES_EN_I, ACCEPT_ERROR_FRAMES_EN_I, ACCEPT_CONTROL_FRAMES_EN_I,
       ACCEPT_SHORT_FRAMES_EN_I, UNICAST_EN_I, MULTICAST_EN_I, BROADCAST_EN_I, ADDR_HIT_I,
       MATCH_OR_FILTER_BIT_I, IS_UNICAST_I,
       IS_BROADCAST_I, IS_CONTROL_I, CODE_ERR_I, ALIGN_ERR_I, CRC_ERR_I, FIFO_SOF_OVERRUN_I,
       DMA_SOF_OVERRUN_I, FIFO_MIDDLE_OVERRUN_I, DMA_MIDDLE_OVERRUN_I, DATA_READY_I, go, rnd_rdy} = '0;
      {RST_I, CE_I, es, em, ed, MATCH_CHANNEL_I, PROMISC_CHANNEL_SEL_I} = {2'h3, 96'h0, 6'h15};
      RX_MAX_FRAME_LEN_I = MAXL;
      flen = 16'h0001;
      lens = '{16'h0014, 16'h003f, 16'h0040, 16'h0050, 16'h0051, 16'h0064, 16'h0001, 16'h0048};
      ov = '{7'b1000100, 7'b0100100, 7'b0010100, 7'b0010101, 7'b0010011, 7'b0010010,
             7'b0001101};
      repeat (4) @(negedge CLOCK_I);
      RST_I = 1'b0;
      {ADDR_HIT_I, MATCH_OR_FILTER_BIT_I, IS_UNICAST_I, UNICAST_EN_I} = 4'hf;
      send(16'h0040);
      chk(32'(FIFO_FULL_O), 32'h1);
      for (i = 0; i < 16; i++) begin
         chk(32'(DATA_O), 32'((8'h40 - 8'(i)) ^ 8'h5a));
         DATA_READY_I = 1'b1;
         @(negedge CLOCK_I);
      end
      DATA_READY_I = 1'b0;
      chk(32'(DATA_VALID_O), 32'h0);
      rnd_rdy = 1'b1;
      for (i = 0; i < 96; i++) begin
         r = $random(seed);
         {ACCEPT_ALL_FRAMES_EN_I, ACCEPT_ERROR_FRAMES_EN_I, ACCEPT_CONTROL_FRAMES_EN_I,
          ACCEPT_SHORT_FRAMES_EN_I} = 4'(i);
         {ADDR_HIT_I, IS_UNICAST_I, IS_CONTROL_I, UNICAST_EN_I, MULTICAST_EN_I, BROADCAST_EN_I,
          MATCH_CHANNEL_I, PROMISC_CHANNEL_SEL_I} = r[11:0];
         CRC_ERR_I = r[15] & r[16];
         CODE_ERR_I = r[17] & r[18] & r[19];
         ALIGN_ERR_I = r[20] & r[21] & r[22];
         IS_BROADCAST_I = r[23] & !IS_UNICAST_I;
         MATCH_OR_FILTER_BIT_I = r[24] | r[25];
         send(lens[r[28:26]]);
      end
      {CRC_ERR_I, CODE_ERR_I, ALIGN_ERR_I, IS_CONTROL_I, IS_BROADCAST_I} = '0;
      {MATCH_OR_FILTER_BIT_I, IS_UNICAST_I, UNICAST_EN_I} = 3'h7;
      for (i = 0; i < 7; i++) begin
         {FIFO_SOF_OVERRUN_I, DMA_SOF_OVERRUN_I, FIFO_MIDDLE_OVERRUN_I, DMA_MIDDLE_OVERRUN_I,
          ADDR_HIT_I, ACCEPT_ALL_FRAMES_EN_I, ACCEPT_ERROR_FRAMES_EN_I} = ov[i];
         send(16'h0040);
      end
      wrap_up();
   end
endmodule : rfa_filter_tb
